// >>> dcf_pkg.sv
// Shared constants and types for the dual clock flag-synchronised FIFO
package dcf_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS       = 25;
    localparam int EMPTY_FULL_SKEW_NS  = 10;
    localparam int ALMOST_SKEW_NS      = 18;
    // Least times round up to whole sys_clk cycles, never below one
    localparam int EF_RAW_CYC = (EMPTY_FULL_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AE_RAW_CYC = (ALMOST_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EMPTY_FULL_SKEW_CYC = (EF_RAW_CYC < 1) ? 1 : EF_RAW_CYC;
    localparam int ALMOST_SKEW_CYC     = (AE_RAW_CYC < 1) ? 1 : AE_RAW_CYC;

    // ********************************************************************
    // Offsets and reset values
    // ********************************************************************
    localparam logic [7:0]  OFFSET_LSB_DEFAULT = 8'h07;
    localparam logic [7:0]  OFFSET_MSB_DEFAULT = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h00;
    localparam logic [7:0]  REG_MASK    = 8'h04;
    localparam logic [7:0]  REG_FLAGS   = 8'h08;
    localparam logic [7:0]  REG_OFFSETS = 8'h0C;
    localparam logic [3:0]  STATUS_RESET = 4'h0;
    localparam logic [3:0]  MASK_RESET   = 4'h0;
    localparam logic [8:0]  DATA_OUT_RESET = 9'h000;

    // Status bit positions
    localparam int EV_FULL       = 0;
    localparam int EV_EMPTY      = 1;
    localparam int EV_WR_REFUSED = 2;
    localparam int EV_RD_REFUSED = 3;
    localparam int EV_W          = 4;

    // Flags register bit positions
    localparam int FLG_EMPTY_N  = 0;
    localparam int FLG_FULL_N   = 1;
    localparam int FLG_AE_N     = 2;
    localparam int FLG_AF_N     = 3;
    localparam int FLG_LOAD     = 4;
    localparam int FLG_LEVEL_LO = 16;

    typedef enum logic [1:0] {INIT_SYNC1, INIT_SYNC2, INIT_STRAP, INIT_RUN} dcf_init_t;

endpackage

// >>> dcf_ptr_if.sv
// Pointer bundle between the FIFO core and its pointer transfer stage
`timescale 1ns/1ps
interface dcf_ptr_if #(parameter int PW = 7);
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] wptr_ef;
    logic [PW-1:0] wptr_ae;
    logic [PW-1:0] rptr_ff;
    logic [PW-1:0] rptr_af;
    modport core (output wptr, output rptr,
                  input wptr_ef, input wptr_ae, input rptr_ff, input rptr_af);
    modport xfer (input wptr, input rptr,
                  output wptr_ef, output wptr_ae, output rptr_ff, output rptr_af);
endinterface

// >>> dcf_ptr_xfer.sv
// Pointer transfer stage: delays each pointer before the opposite side sees it
`timescale 1ns/1ps
module dcf_ptr_xfer #(
    parameter int PW        = 7,
    parameter int EF_STAGES = 1,
    parameter int AE_STAGES = 1
) (
    input  wire logic    sys_clk_i,
    input  wire logic    rst_n_i,
    dcf_ptr_if.xfer      xp
);

    logic [PW-1:0] wef_reg  [EF_STAGES];
    logic [PW-1:0] wef_next [EF_STAGES];
    logic [PW-1:0] rff_reg  [EF_STAGES];
    logic [PW-1:0] rff_next [EF_STAGES];
    logic [PW-1:0] wae_reg  [AE_STAGES];
    logic [PW-1:0] wae_next [AE_STAGES];
    logic [PW-1:0] raf_reg  [AE_STAGES];
    logic [PW-1:0] raf_next [AE_STAGES];

    // ********************************************************************
    // Shift pipelines
    // ********************************************************************
    // Stage depth stands for the skew minimum: a pointer move is seen by
    // the far side only once that much time has passed
    always_comb begin
        wef_next[0] = xp.wptr;
        rff_next[0] = xp.rptr;
        wae_next[0] = xp.wptr;
        raf_next[0] = xp.rptr;
        for (int i = 1; i < EF_STAGES; i++) begin
            wef_next[i] = wef_reg[i-1];
            rff_next[i] = rff_reg[i-1];
        end
        for (int i = 1; i < AE_STAGES; i++) begin
            wae_next[i] = wae_reg[i-1];
            raf_next[i] = raf_reg[i-1];
        end
    end

    // Registers only; reset to the empty pointer value
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < EF_STAGES; i++) begin
                wef_reg[i] <= '0;
                rff_reg[i] <= '0;
            end
            for (int i = 0; i < AE_STAGES; i++) begin
                wae_reg[i] <= '0;
                raf_reg[i] <= '0;
            end
        end else begin
            wef_reg <= wef_next;
            rff_reg <= rff_next;
            wae_reg <= wae_next;
            raf_reg <= raf_next;
        end
    end

    // Flags only ever compare against these delayed copies
    assign xp.wptr_ef = wef_reg[EF_STAGES-1];
    assign xp.rptr_ff = rff_reg[EF_STAGES-1];
    assign xp.wptr_ae = wae_reg[AE_STAGES-1];
    assign xp.rptr_af = raf_reg[AE_STAGES-1];

endmodule

// >>> dcf_fifo.sv
// Nine-bit dual-clock FIFO with pin-sampled clocks, flags and AHB-Lite status
`timescale 1ns/1ps
module dcf_fifo #(
    parameter int DEPTH = 64
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        wr_clk_i,
    input  wire logic        rd_clk_i,
    input  wire logic [8:0]  data_in_i,
    input  wire logic        primary_write_enable_n_i,
    input  wire logic        second_write_enable_or_load_select_i,
    input  wire logic        primary_read_enable_n_i,
    input  wire logic        second_read_enable_n_i,
    input  wire logic        output_enable_n_i,
    output logic      [8:0]  data_out_o,
    output logic             data_out_oe_o,
    output logic             empty_flag_n_o,
    output logic             full_flag_n_o,
    output logic             almost_empty_flag_n_o,
    output logic             almost_full_flag_n_o,
    output logic             irq_o,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
    localparam logic [16:0]   DEPTH_X = 17'(DEPTH);

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    // Two flops per pin; the third clock flop only serves edge detection
    logic [1:0] wclk_s;
    logic [1:0] rclk_s;
    logic       wclk_d;
    logic       rclk_d;
    logic [8:0] din_s1;
    logic [8:0] din_s2;
    logic [4:0] ctl_s1;
    logic [4:0] ctl_s2;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wclk_s <= 2'h0;
            rclk_s <= 2'h0;
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
            din_s1 <= 9'h000;
            din_s2 <= 9'h000;
            ctl_s1 <= 5'h1F;
            ctl_s2 <= 5'h1F;
        end else begin
            wclk_s <= {wclk_s[0], wr_clk_i};
            rclk_s <= {rclk_s[0], rd_clk_i};
            wclk_d <= wclk_s[1];
            rclk_d <= rclk_s[1];
            din_s1 <= data_in_i;
            din_s2 <= din_s1;
            ctl_s1 <= {output_enable_n_i, second_read_enable_n_i, primary_read_enable_n_i,
                       second_write_enable_or_load_select_i, primary_write_enable_n_i};
            ctl_s2 <= ctl_s1;
        end
    end

    logic wr_edge;
    logic rd_edge;
    logic we_n_s;
    logic ld_s;
    logic re1_n_s;
    logic re2_n_s;
    logic oe_n_s;

    // Edges are found from the second flop onward only
    assign wr_edge = wclk_s[1] & ~wclk_d;
    assign rd_edge = rclk_s[1] & ~rclk_d;
    assign {oe_n_s, re2_n_s, re1_n_s, ld_s, we_n_s} = ctl_s2;

    // ********************************************************************
    // Reset strap and pointer transfer
    // ********************************************************************
    dcf_pkg::dcf_init_t init_reg;
    dcf_pkg::dcf_init_t init_next;
    logic               load_mode_reg;
    logic               load_mode_next;

    // Strap is taken once the synchronised pin is valid, never at reset time
    always_comb begin
        init_next      = init_reg;
        load_mode_next = load_mode_reg;
        case (init_reg)
            dcf_pkg::INIT_SYNC1: init_next = dcf_pkg::INIT_SYNC2;
            dcf_pkg::INIT_SYNC2: init_next = dcf_pkg::INIT_STRAP;
            dcf_pkg::INIT_STRAP: begin
                init_next      = dcf_pkg::INIT_RUN;
                load_mode_next = ~ld_s;
            end
            dcf_pkg::INIT_RUN:   init_next = dcf_pkg::INIT_RUN;
            default:             init_next = dcf_pkg::INIT_SYNC1;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_reg      <= dcf_pkg::INIT_SYNC1;
            load_mode_reg <= 1'b0;
        end else begin
            init_reg      <= init_next;
            load_mode_reg <= load_mode_next;
        end
    end

    dcf_ptr_if #(.PW(PW)) ptr_bus ();

    dcf_ptr_xfer #(
        .PW        (PW),
        .EF_STAGES (dcf_pkg::EMPTY_FULL_SKEW_CYC),
        .AE_STAGES (dcf_pkg::ALMOST_SKEW_CYC)
    ) u_ptr_xfer (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .xp        (ptr_bus.xfer)
    );

    function automatic logic [PW-1:0] ptr_gap(input logic [PW-1:0] a, input logic [PW-1:0] b);
        return a - b;
    endfunction

    // ********************************************************************
    // FIFO core
    // ********************************************************************
    logic [8:0]    mem_reg [DEPTH];
    logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic          ff_reg, ff_next, ef_reg, ef_next, af_reg, af_next, ae_reg, ae_next;
    logic [8:0]    dout_reg, dout_next;
    logic [7:0]    off_reg  [4];
    logic [7:0]    off_next [4];
    logic [1:0]    wsel_reg, wsel_next, rsel_reg, rsel_next;
    logic          do_write;
    logic [PW-1:0] wlvl, rlvl;
    logic [15:0]   n_off, m_off;
    localparam int EV_W_T = dcf_pkg::EV_W;
    logic [EV_W_T-1:0] ev;
    logic          run, fifo_wr, off_wr, fifo_rd, off_rd;

    assign run     = (init_reg == dcf_pkg::INIT_RUN);
    assign fifo_wr = ~we_n_s & ld_s;
    assign off_wr  = load_mode_reg & ~we_n_s & ~ld_s;
    assign fifo_rd = ~re1_n_s & ~re2_n_s & ~(load_mode_reg & ~ld_s);
    assign off_rd  = load_mode_reg & ~ld_s & ~re1_n_s & ~re2_n_s;
    assign n_off   = {off_reg[1], off_reg[0]};
    assign m_off   = {off_reg[3], off_reg[2]};
    assign ptr_bus.wptr = wptr_reg;
    assign ptr_bus.rptr = rptr_reg;

    // Each side moves only on its own detected edge and sees the far
    // pointer late; a flag may therefore lag one edge, never lead
    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        ff_next   = ff_reg;
        ef_next   = ef_reg;
        af_next   = af_reg;
        ae_next   = ae_reg;
        dout_next = dout_reg;
        off_next  = off_reg;
        wsel_next = wsel_reg;
        rsel_next = rsel_reg;
        do_write  = 1'b0;
        ev        = '0;
        wlvl      = '0;
        rlvl      = '0;
        if (run && wr_edge) begin
            if (fifo_wr && ff_reg) begin
                do_write  = 1'b1;
                wptr_next = PW'(wptr_reg + 1'b1);
            end else if (fifo_wr) begin
                ev[dcf_pkg::EV_WR_REFUSED] = 1'b1;
            end else if (off_wr) begin
                off_next[wsel_reg] = din_s2[7:0];
                wsel_next          = 2'(wsel_reg + 1'b1);
            end
            ff_next = (ptr_gap(wptr_next, ptr_bus.rptr_ff) != DEPTH_P);
            wlvl    = ptr_gap(wptr_next, ptr_bus.rptr_af);
            af_next = (17'(wlvl) + 17'(m_off)) < DEPTH_X;
            ev[dcf_pkg::EV_FULL] = ff_reg & ~ff_next;
        end
        if (run && rd_edge) begin
            if (fifo_rd && ef_reg) begin
                dout_next = mem_reg[rptr_reg[AW-1:0]];
                rptr_next = PW'(rptr_reg + 1'b1);
            end else if (fifo_rd) begin
                ev[dcf_pkg::EV_RD_REFUSED] = 1'b1;
            end else if (off_rd) begin
                dout_next = {1'b0, off_reg[rsel_reg]};
                rsel_next = 2'(rsel_reg + 1'b1);
            end
            ef_next = (ptr_bus.wptr_ef != rptr_next);
            rlvl    = ptr_gap(ptr_bus.wptr_ae, rptr_next);
            ae_next = (16'(rlvl) > n_off);
            ev[dcf_pkg::EV_EMPTY] = ef_reg & ~ef_next;
        end
    end

    // Reset works whatever the pin clocks do: edges are ignored until run
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            ff_reg   <= 1'b1;
            ef_reg   <= 1'b0;
            af_reg   <= 1'b1;
            ae_reg   <= 1'b0;
            dout_reg <= dcf_pkg::DATA_OUT_RESET;
            off_reg[0] <= dcf_pkg::OFFSET_LSB_DEFAULT;
            off_reg[1] <= dcf_pkg::OFFSET_MSB_DEFAULT;
            off_reg[2] <= dcf_pkg::OFFSET_LSB_DEFAULT;
            off_reg[3] <= dcf_pkg::OFFSET_MSB_DEFAULT;
            wsel_reg <= 2'h0;
            rsel_reg <= 2'h0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            ff_reg   <= ff_next;
            ef_reg   <= ef_next;
            af_reg   <= af_next;
            ae_reg   <= ae_next;
            dout_reg <= dout_next;
            off_reg  <= off_next;
            wsel_reg <= wsel_next;
            rsel_reg <= rsel_next;
        end
    end

    // Storage has no reset; unread words are never shown
    always_ff @(posedge sys_clk_i) begin
        if (do_write) begin
            mem_reg[wptr_reg[AW-1:0]] <= din_s2;
        end
    end

    assign data_out_o            = dout_reg;
    assign data_out_oe_o         = ~oe_n_s;
    assign empty_flag_n_o        = ef_reg;
    assign full_flag_n_o         = ff_reg;
    assign almost_empty_flag_n_o = ae_reg;
    assign almost_full_flag_n_o  = af_reg;

    // ********************************************************************
    // AHB-Lite slave and interrupt
    // ********************************************************************
    logic [3:0]  status_reg, status_next, mask_reg, mask_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic        wr_ph_reg, wr_ph_next;
    logic [7:0]  wad_reg, wad_next;
    logic        acc;
    logic [31:0] flags_word;

    assign acc = hsel_i & htrans_i[1] & hready_i;
    assign flags_word = {{(16 - PW){1'b0}}, ptr_gap(wptr_reg, rptr_reg), 11'h000,
                         load_mode_reg, af_reg, ae_reg, ff_reg, ef_reg};

    // Read clear happens at the address phase; a same-cycle event still sets
    always_comb begin
        status_next = status_reg | ev;
        mask_next   = mask_reg;
        hrdata_next = hrdata_reg;
        wr_ph_next  = acc & hwrite_i;
        wad_next    = acc ? haddr_i[7:0] : wad_reg;
        if (wr_ph_reg && wad_reg == dcf_pkg::REG_MASK) begin
            mask_next = hwdata_i[3:0];
        end
        if (acc && !hwrite_i) begin
            case (haddr_i[7:0])
                dcf_pkg::REG_STATUS: begin
                    hrdata_next = {28'h0000000, status_reg};
                    status_next = ev;
                end
                dcf_pkg::REG_MASK:    hrdata_next = {28'h0000000, mask_reg};
                dcf_pkg::REG_FLAGS:   hrdata_next = flags_word;
                dcf_pkg::REG_OFFSETS: hrdata_next = {m_off, n_off};
                default:              hrdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_reg <= dcf_pkg::STATUS_RESET;
            mask_reg   <= dcf_pkg::MASK_RESET;
            hrdata_reg <= 32'h00000000;
            wr_ph_reg  <= 1'b0;
            wad_reg    <= 8'h00;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            hrdata_reg <= hrdata_next;
            wr_ph_reg  <= wr_ph_next;
            wad_reg    <= wad_next;
        end
    end

    assign hrdata_o    = hrdata_reg;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign irq_o       = |(status_reg & mask_reg);

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic rd_seen_reg;
    logic [8:0] head_word;
    assign head_word = mem_reg[rptr_reg[AW-1:0]];
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_seen_reg <= 1'b0;
        end else if (run && rd_edge && (fifo_rd || off_rd)) begin
            rd_seen_reg <= 1'b1;
        end
    end

    a_out_low_reset: assert property (!rd_seen_reg |-> dout_reg == 9'h000)
        else $error("data output not low before first read");
    a_oe_follows_pin: assert property (oe_n_s |-> !data_out_oe_o)
        else $error("data driven while output enable high");
    a_strap_taken: assert property (init_reg == dcf_pkg::INIT_STRAP |=> load_mode_reg == !$past(ld_s))
        else $error("strap mode not taken from pin");
    a_full_blocks: assert property (!ff_reg && wr_edge |=> $stable(wptr_reg))
        else $error("write accepted while full");
    a_empty_blocks: assert property (!ef_reg && rd_edge |=> $stable(rptr_reg))
        else $error("read accepted while empty");
    a_first_word: assert property (run && rd_edge && fifo_rd && ef_reg |=> dout_reg == $past(head_word))
        else $error("head word not presented on read edge");
    a_ef_own_edge: assert property (!rd_edge |=> $stable(ef_reg) && $stable(ae_reg))
        else $error("read side flag moved off its edge");
    a_ff_own_edge: assert property (!wr_edge |=> $stable(ff_reg) && $stable(af_reg))
        else $error("write side flag moved off its edge");
    a_ae_level: assert property (run && rd_edge |=> ae_reg == ($past(rlvl) > 16'($past(n_off))))
        else $error("almost empty level wrong");
    a_af_thresh: assert property (run && wr_edge |=> af_reg == (17'($past(wlvl)) + 17'($past(m_off)) < DEPTH_X))
        else $error("almost full threshold wrong");
    a_offset_default: assert property (wsel_reg == 2'h0 && $stable(wsel_reg) && init_reg != dcf_pkg::INIT_RUN |-> n_off == 16'h0007 && m_off == 16'h0007)
        else $error("offsets not at default");
    a_ef_release: assert property (run && wr_edge && fifo_wr && ff_reg ##[2:8] rd_edge |=> ef_reg)
        else $error("empty flag not released after skew");

endmodule

// >>> dcf_link_model.sv
// Writer and reader side pin clocks for the dual clock FIFO
`timescale 1ns/1ps
module dcf_link_model (
    output logic wr_clk_o,
    output logic rd_clk_o
);
    // Both pin clocks run free, reset included, 200 ns period
    // The read clock is offset so edges of the two sides never line up
    initial begin
        wr_clk_o = 1'b0;
        forever #100 wr_clk_o = ~wr_clk_o;
    end
    initial begin
        rd_clk_o = 1'b0;
        #73;
        forever #100 rd_clk_o = ~rd_clk_o;
    end
endmodule

// >>> dcf_fifo_test.sv
// Self-checking bench for the dual clock FIFO: flags, data order, status bus
`timescale 1ns/1ps
module dcf_fifo_test;
    localparam int DEPTH = 64;
    localparam int OFS   = 7;
    logic        sys_clk, rst_n, wr_clk, rd_clk, we_n, we2, re_n, oe_n, hsel, hwrite;
    logic        oe, e_n, f_n, ae_n, af_n, irq, hrdy, hresp;
    logic [8:0]  din, dout, last;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [8:0]  q[$];
    int          bad_count, samples_checked;

    dcf_link_model dcf_link_model_inst (.wr_clk_o(wr_clk), .rd_clk_o(rd_clk));
    dcf_fifo #(.DEPTH(DEPTH)) dcf_fifo_inst (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .wr_clk_i(wr_clk), .rd_clk_i(rd_clk),
        .data_in_i(din), .primary_write_enable_n_i(we_n),
        .second_write_enable_or_load_select_i(we2), .primary_read_enable_n_i(re_n),
        .second_read_enable_n_i(re_n), .output_enable_n_i(oe_n), .data_out_o(dout),
        .data_out_oe_o(oe), .empty_flag_n_o(e_n), .full_flag_n_o(f_n),
        .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n), .irq_o(irq),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp));

    // Verdict and end of run, shared by the main sequence and the watchdog
    task end_sim;
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; entered just after a rising edge
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
        do @(posedge sys_clk); while (hrdy !== 1'b1);
        htrans <= 2'h0; hwdata <= wd;
        do @(posedge sys_clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask

    // n enabled pin-clock edges; at a boundary the last of them is refused
    task op(input bit wr, input int n);
        for (int i = 0; i <= n; i++) begin
            if (wr) @(negedge wr_clk); else @(negedge rd_clk);
            repeat ((i > 0) ? 2 : 1) @(posedge sys_clk);
            if (i > 0 && wr) begin
                if (q.size() < DEPTH) q.push_back(din);
                chk(f_n, q.size() < DEPTH);
                chk(af_n, q.size() < DEPTH - OFS);
            end
            if (i > 0 && !wr) begin
                if (q.size() > 0) last = q.pop_front();
                chk(dout, last);
                chk(e_n, q.size() > 0);
                chk(ae_n, q.size() > OFS);
            end
            if (wr) begin
                we_n <= (i == n);
                din <= 9'(9'h1A5 + i * 37);
            end else re_n <= (i == n);
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Hang guard, far beyond the roughly 1200 cycles the sequence needs
    initial begin
        #250000;
        bad_count++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0; we_n = 1'b1; we2 = 1'b1; re_n = 1'b1; oe_n = 1'b0; din = 9'h000;
        hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
        last = 9'h000; bad_count = 0; samples_checked = 0;
        repeat (4) @(posedge sys_clk);
        chk({e_n, f_n, ae_n, af_n, irq}, 5'h0A);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({oe, dout}, 10'h200);
        oe_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk(oe, 1'b0);
        oe_n <= 1'b0;
        ahb(1'b0, 32'h0C, 32'h0);
        chk(rd, 32'h0007_0007);
        ahb(1'b0, 32'h08, 32'h0);
        chk(rd, 32'h0000_000A);
        // Single word: empty releases, then first word one read edge later
        op(1'b1, 1);
        for (int i = 0; i < 40 && e_n !== 1'b1; i++) @(posedge sys_clk);
        chk(e_n, 1'b1);
        op(1'b0, 1);
        ahb(1'b0, 32'h00, 32'h0);
        // Fill past full, then raise, mask and clear the interrupt
        op(1'b1, DEPTH + 1);
        chk(irq, 1'b0);
        ahb(1'b1, 32'h04, 32'hF);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        ahb(1'b0, 32'h00, 32'h0);
        chk(rd, 32'h5);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        // Drain past empty; order kept, refused read leaves data alone
        op(1'b0, DEPTH + 1);
        ahb(1'b0, 32'h00, 32'h0);
        chk(rd, 32'hA);
        repeat (40) @(posedge sys_clk);
        chk({f_n, af_n}, 2'h3);
        // Second reset with the pin held low: it becomes the offset load select
        rst_n <= 1'b0;
        we2 <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk({e_n, f_n, ae_n, af_n, irq}, 5'h0A);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        // Offsets load in order n low, n high, m low, m high
        for (int i = 0; i <= 4; i++) begin
            @(negedge wr_clk);
            @(posedge sys_clk);
            we_n <= (i == 4);
            din <= (i == 0) ? 9'h003 : ((i == 2) ? 9'h005 : 9'h000);
        end
        ahb(1'b0, 32'h0C, 32'h0);
        chk(rd, 32'h0005_0003);
        ahb(1'b0, 32'h08, 32'h0);
        chk(rd[4], 1'b1);
        end_sim();
    end
endmodule
